// ---- rtl/adc_seq_pkg.sv ----
// Shared constants and types of the single-channel converter sequencer
`default_nettype none
package adc_seq_pkg;
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL_FIRST  = 8'h00;
   localparam logic [7:0] OFS_CTRL_SECOND = 8'h04;
   localparam logic [7:0] OFS_INSEL       = 8'h08;
   localparam logic [7:0] OFS_MODE        = 8'h0c;
   localparam logic [7:0] OFS_REFCTRL     = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h18;
   localparam logic [7:0] OFS_RESULT0     = 8'h20;
   localparam logic [7:0] OFS_RESULT7     = 8'h3c;
   // Field positions
   localparam int POS_START       = 0;
   localparam int POS_EXTEND      = 0;
   localparam int POS_WIDTH10     = 1;
   localparam int POS_ASSIST_EN   = 2;
   localparam int POS_ASSIST_CHG  = 3;
   localparam int POS_CH_LO       = 0;
   localparam int POS_GRP_LO      = 4;
   localparam int POS_MODE_LO     = 0;
   localparam int POS_TRIG_LO     = 4;
   localparam int POS_REF_ROUTE   = 0;
   localparam int POS_IRQ_DONE    = 0;
   // Reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   // Timing, in converter clock cycles
   localparam int CONV_CYC_PLAIN  = 40;
   localparam int CONV_CYC_ASSIST = 42;
   localparam int ASSIST_PRE_CYC  = CONV_CYC_ASSIST - CONV_CYC_PLAIN;
   localparam logic [5:0] CONV_PLAIN_T  = 6'(CONV_CYC_PLAIN);
   localparam logic [5:0] ASSIST_PRE_T  = 6'(ASSIST_PRE_CYC);
   // Encodings
   localparam logic [1:0] TRIG_SOFT  = 2'h0;
   localparam logic [1:0] TRIG_TIMER = 2'h2;
   localparam logic [1:0] TRIG_EXT   = 2'h3;
   localparam logic [1:0] MODE_ONESHOT = 2'h0;
   localparam logic [1:0] MODE_REPEAT0 = 2'h1;
   localparam int RESULT_W = 10;
   typedef enum logic [1:0] {ST_IDLE, ST_ASSIST, ST_CONV} seq_e;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_s;
   typedef struct packed {
      logic [3:0] source;
      logic       isRef;
   } chan_s;
endpackage
`default_nettype wire

// ---- rtl/adc_single_channel_sequencer.sv ----
// Single-channel converter sequencer: one-shot and repeat mode 0 control
//
// The implementer's own choices: the address map and strobed register access.
`default_nettype none
module adc_single_channel_sequencer
   import adc_seq_pkg::*;
#(
   parameter int RW = RESULT_W
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          arst_n,
   // Register port
   input  wire logic [7:0]    regAddr,
   input  wire logic [31:0]   regWdata,
   input  wire logic          regWr,
   input  wire logic          regRd,
   output logic      [31:0]   regRdata,
   // Trigger sources
   input  wire logic          timerMatch,
   input  wire logic          extTrigPin,
   // Analog front end
   input  wire logic [RW-1:0] convSample,
   output logic      [3:0]    analogSelect,
   output logic               refRouteOn,
   output logic               sampleEnable,
   output logic               capPrecharge,
   output logic               capDischarge,
   // Interrupt
   output logic               irq
);
   bus_req_s req;
   assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

   // Software-visible control state
   logic       start_ff, nxt_start;
   logic [3:0] second_ff, nxt_second;
   logic [5:0] insel_ff, nxt_insel;
   logic [5:0] mode_ff, nxt_mode;
   logic       route_ff, nxt_route;
   logic       stat_ff, nxt_stat;
   logic       mask_ff, nxt_mask;
   logic [31:0] rdata_ff, nxt_rdata;
   logic       rdRes_ff, nxt_rdRes;
   // Sequencer state
   seq_e       state_ff, nxt_state;
   logic [5:0] cnt_ff, nxt_cnt;
   logic [3:0] sel_ff, nxt_sel;
   logic       refOn_ff, nxt_refOn;
   logic       samp_ff, nxt_samp;
   logic       pre_ff, nxt_pre;
   logic       dis_ff, nxt_dis;
   logic       irq_ff, nxt_irq;
   logic       we_ff, nxt_we;
   logic [2:0] wa_ff, nxt_wa;
   logic [RW-1:0] wd_ff, nxt_wd;
   // Synchronisers
   logic       extS1_ff, extS2_ff, extS3_ff;
   logic       tmrS1_ff, tmrS2_ff, tmrS3_ff;

   logic [1:0] trig, mode;
   logic       extend, width10, assistEn, assistChg;
   logic       trigEvt, done, validMode, swStop;
   logic [RW-1:0] resData;
   chan_s      chan;

   assign extend    = second_ff[POS_EXTEND];
   assign width10   = second_ff[POS_WIDTH10];
   assign assistEn  = second_ff[POS_ASSIST_EN];
   assign assistChg = second_ff[POS_ASSIST_CHG];
   assign trig      = mode_ff[POS_TRIG_LO +: 2];
   assign mode      = mode_ff[POS_MODE_LO +: 2];
   assign validMode = (mode == MODE_ONESHOT) || (mode == MODE_REPEAT0);

   // Maps a channel to its result register slot
   function automatic logic [2:0] slot_of(input chan_s c);
      if (c.isRef) begin
         return 3'h0;
      end
      return (c.source < 4'h8) ? c.source[2:0] : {1'b0, c.source[1:0]};
   endfunction

   always_comb begin
      chan.isRef  = extend && route_ff && validMode;
      chan.source = 4'({insel_ff[POS_GRP_LO +: 2], 2'b00}) + {1'b0, insel_ff[POS_CH_LO +: 3]};
      if (insel_ff[POS_GRP_LO +: 2] == 2'h1) begin
         chan.source = {1'b1, insel_ff[POS_CH_LO +: 3]};
      end else if (insel_ff[POS_GRP_LO +: 2] == 2'h0) begin
         chan.source = {1'b0, insel_ff[POS_CH_LO +: 3]};
      end
      if (chan.source > 4'hb) begin
         chan.source = 4'hb;
      end
   end

   // Pins are asynchronous; the second and third stages feed the edge detector
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         extS1_ff <= 1'b1;
         extS2_ff <= 1'b1;
         extS3_ff <= 1'b1;
         tmrS1_ff <= 1'b0;
         tmrS2_ff <= 1'b0;
         tmrS3_ff <= 1'b0;
      end else begin
         extS1_ff <= extTrigPin;
         extS2_ff <= extS1_ff;
         extS3_ff <= extS2_ff;
         tmrS1_ff <= timerMatch;
         tmrS2_ff <= tmrS1_ff;
         tmrS3_ff <= tmrS2_ff;
      end
   end

   always_comb begin
      unique case (trig)
         TRIG_TIMER: trigEvt = tmrS2_ff && !tmrS3_ff;
         TRIG_EXT:   trigEvt = !extS2_ff && extS3_ff;
         default:    trigEvt = 1'b1;
      endcase
   end

   assign done   = (state_ff == ST_CONV) && (cnt_ff == 6'h1);
   assign swStop = req.wr && (req.addr == OFS_CTRL_FIRST) && !req.wdata[POS_START];
   assign resData = width10 ? convSample : {2'b00, convSample[RW-1:2]};

   // Register file next values
   always_comb begin
      nxt_start  = start_ff;
      nxt_second = second_ff;
      nxt_insel  = insel_ff;
      nxt_mode   = mode_ff;
      nxt_route  = route_ff;
      nxt_mask   = mask_ff;
      nxt_stat   = stat_ff;
      nxt_rdRes  = 1'b0;
      nxt_rdata  = '0;
      if (done && mode == MODE_ONESHOT && trig == TRIG_SOFT) begin
         nxt_start = 1'b0;
      end
      if (req.wr) begin
         unique case (req.addr)
            OFS_CTRL_FIRST:  nxt_start  = req.wdata[POS_START];
            OFS_CTRL_SECOND: nxt_second = req.wdata[3:0];
            OFS_INSEL:       nxt_insel  = req.wdata[5:0];
            OFS_MODE:        nxt_mode   = req.wdata[5:0];
            OFS_REFCTRL:     nxt_route  = req.wdata[POS_REF_ROUTE];
            OFS_IRQ_STATUS:  nxt_stat   = stat_ff && !req.wdata[POS_IRQ_DONE];
            OFS_IRQ_MASK:    nxt_mask   = req.wdata[POS_IRQ_DONE];
            default:         ;
         endcase
      end
      // one-shot completion sets status, set beats clear
      if (done && mode == MODE_ONESHOT && !swStop) begin
         nxt_stat = 1'b1;
      end
      if (req.rd) begin
         unique case (req.addr)
            OFS_CTRL_FIRST:  nxt_rdata = {31'h0, start_ff};
            OFS_CTRL_SECOND: nxt_rdata = {28'h0, second_ff};
            OFS_INSEL:       nxt_rdata = {26'h0, insel_ff};
            OFS_MODE:        nxt_rdata = {26'h0, mode_ff};
            OFS_REFCTRL:     nxt_rdata = {31'h0, route_ff};
            OFS_IRQ_STATUS:  nxt_rdata = {31'h0, stat_ff};
            OFS_IRQ_MASK:    nxt_rdata = {31'h0, mask_ff};
            default: begin
               nxt_rdRes = (req.addr >= OFS_RESULT0) && (req.addr <= OFS_RESULT7)
                           && (req.addr[1:0] == 2'b00);
            end
         endcase
      end
   end

   // Sequencer next values
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_sel   = sel_ff;
      nxt_refOn = refOn_ff;
      nxt_samp  = 1'b0;
      nxt_pre   = 1'b0;
      nxt_dis   = 1'b0;
      nxt_we    = 1'b0;
      nxt_wa    = wa_ff;
      nxt_wd    = wd_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (start_ff && !swStop && trigEvt && validMode) begin
               nxt_sel   = chan.source;
               nxt_refOn = chan.isRef;
               nxt_wa    = slot_of(chan);
               if (assistEn) begin
                  nxt_state = ST_ASSIST;
                  nxt_cnt   = ASSIST_PRE_T;
               end else begin
                  nxt_state = ST_CONV;
                  nxt_cnt   = CONV_PLAIN_T;
               end
            end
         end
         ST_ASSIST: begin
            nxt_pre = assistChg;
            nxt_dis = !assistChg;
            nxt_cnt = cnt_ff - 6'h1;
            if (cnt_ff == 6'h1) begin
               nxt_state = ST_CONV;
               nxt_cnt   = CONV_PLAIN_T;
            end
         end
         ST_CONV: begin
            nxt_samp = 1'b1;
            nxt_cnt  = cnt_ff - 6'h1;
            if (done) begin
               nxt_samp = 1'b0;
               // slot by channel, reference into slot zero
               nxt_we    = 1'b1;
               nxt_wd    = resData;
               nxt_state = ST_IDLE;
               if (mode == MODE_REPEAT0 && !swStop) begin
                  nxt_state = assistEn ? ST_ASSIST : ST_CONV;
                  nxt_cnt   = assistEn ? ASSIST_PRE_T : CONV_PLAIN_T;
               end
            end
         end
      endcase
      // abort on clear, no result; repeat also ends at done if mode is rewritten
      if (swStop && state_ff != ST_IDLE) begin
         nxt_state = ST_IDLE;
         nxt_we    = 1'b0;
         nxt_samp  = 1'b0;
         nxt_pre   = 1'b0;
         nxt_dis   = 1'b0;
      end
      // no interrupt in repeat, status gated by swStop above
      nxt_irq = (nxt_stat && mask_ff);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         start_ff  <= 1'b0;
         second_ff <= 4'h0;
         insel_ff  <= 6'h00;
         mode_ff   <= 6'h00;
         route_ff  <= 1'b0;
         stat_ff   <= 1'b0;
         mask_ff   <= 1'b0;
         rdata_ff  <= RST_ZERO;
         rdRes_ff  <= 1'b0;
         state_ff  <= ST_IDLE;
         cnt_ff    <= 6'h00;
         sel_ff    <= 4'h0;
         refOn_ff  <= 1'b0;
         samp_ff   <= 1'b0;
         pre_ff    <= 1'b0;
         dis_ff    <= 1'b0;
         irq_ff    <= 1'b0;
         we_ff     <= 1'b0;
         wa_ff     <= 3'h0;
         wd_ff     <= '0;
      end else begin
         start_ff  <= nxt_start;
         second_ff <= nxt_second;
         insel_ff  <= nxt_insel;
         mode_ff   <= nxt_mode;
         route_ff  <= nxt_route;
         stat_ff   <= nxt_stat;
         mask_ff   <= nxt_mask;
         rdata_ff  <= nxt_rdata;
         rdRes_ff  <= nxt_rdRes;
         state_ff  <= nxt_state;
         cnt_ff    <= nxt_cnt;
         sel_ff    <= nxt_sel;
         refOn_ff  <= nxt_refOn;
         samp_ff   <= nxt_samp;
         pre_ff    <= nxt_pre;
         dis_ff    <= nxt_dis;
         irq_ff    <= nxt_irq;
         we_ff     <= nxt_we;
         wa_ff     <= nxt_wa;
         wd_ff     <= nxt_wd;
      end
   end

   logic [RW-1:0] resRd;
   result_store #(.W(RW)) u_store (
      .clk   (clk),
      .arst_n(arst_n),
      .we    (we_ff),
      .waddr (wa_ff),
      .wdata (wd_ff),
      .raddr (req.addr[4:2]),
      .rdata (resRd)
   );

   // Result reads come from the memory's own output register
   assign regRdata     = rdRes_ff ? 32'(resRd) : rdata_ff;
   assign analogSelect = sel_ff;
   assign refRouteOn   = refOn_ff;
   assign sampleEnable = samp_ff;
   assign capPrecharge = pre_ff;
   assign capDischarge = dis_ff;
   assign irq          = irq_ff;

   // Assertions; a software abort may legally cut either phase short
   a_conv_length: assert property (@(posedge clk) disable iff (!arst_n || swStop)
      $rose(state_ff == ST_CONV) |-> (state_ff == ST_CONV) [*8])
      else $error("conversion shorter than expected");
   a_repeat_noirq: assert property (@(posedge clk) disable iff (!arst_n)
      (mode == MODE_REPEAT0 && done) |=> !$rose(stat_ff))
      else $error("repeat mode raised status");
   a_abort_nowrite: assert property (@(posedge clk) disable iff (!arst_n)
      (swStop && state_ff != ST_IDLE) |=> !we_ff && state_ff == ST_IDLE)
      else $error("abort did not stop");
   a_done_clears: assert property (@(posedge clk) disable iff (!arst_n)
      (done && mode == MODE_ONESHOT && trig == TRIG_SOFT && !req.wr) |=> !start_ff)
      else $error("start bit not cleared");
   a_oneshot_irq: assert property (@(posedge clk) disable iff (!arst_n)
      (done && mode == MODE_ONESHOT && !swStop) |=> stat_ff)
      else $error("no completion status");
   a_ref_slot: assert property (@(posedge clk) disable iff (!arst_n)
      (we_ff && refOn_ff) |-> wa_ff == 3'h0)
      else $error("reference result in wrong slot");
   a_repeat_keeps: assert property (@(posedge clk) disable iff (!arst_n)
      (mode == MODE_REPEAT0 && done && !req.wr) |=> start_ff)
      else $error("repeat cleared start");
   a_assist_first: assert property (@(posedge clk) disable iff (!arst_n || swStop)
      $rose(state_ff == ST_ASSIST) |-> ##1 (pre_ff || dis_ff))
      else $error("assist not applied");
endmodule
`default_nettype wire

// ---- rtl/result_store.sv ----
// Eight-entry result memory with registered read data
`default_nettype none
module result_store #(
   parameter int W = 10
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         arst_n,
   // Write side
   input  wire logic         we,
   input  wire logic [2:0]   waddr,
   input  wire logic [W-1:0] wdata,
   // Read side
   input  wire logic [2:0]   raddr,
   output logic      [W-1:0] rdata
);
   logic [W-1:0] mem [8];
   logic [W-1:0] rdata_ff;
   logic [W-1:0] nxt_rdata;

   always_comb begin
      nxt_rdata = mem[raddr];
   end

   // Contents left unreset; undefined after reset as the converter results are
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end
   assign rdata = rdata_ff;
endmodule
`default_nettype wire

// ---- testbench/adc_single_channel_sequencer_tb.sv ----
// Self-checking bench of the single-channel converter sequencer
`default_nettype none
module adc_single_channel_sequencer_tb
   import adc_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] REF_LEVEL = 10'h2aa;
   logic        clk;
   logic        arst_n;
   logic [7:0]  regAddr;
   logic [31:0] regWdata;
   logic        regWr;
   logic        regRd;
   logic [31:0] regRdata;
   logic        timerMatch;
   logic        extTrigPin;
   logic [9:0]  convSample;
   logic [9:0]  offset;
   logic [3:0]  analogSelect;
   logic        refRouteOn;
   logic        sampleEnable;
   logic        capPrecharge;
   logic        capDischarge;
   logic        irq;
   logic [15:0] lfsr;
   logic [31:0] rdv;
   int          n_fail;
   int          checks_done;
   int          seRun;
   int          seLen;
   int          nConv;
   int          pcCnt;
   int          dcCnt;
   int          n0;

   adc_single_channel_sequencer #(.RW(10)) dut (.clk(clk), .arst_n(arst_n),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .timerMatch(timerMatch), .extTrigPin(extTrigPin),
      .convSample(convSample), .analogSelect(analogSelect), .refRouteOn(refRouteOn),
      .sampleEnable(sampleEnable), .capPrecharge(capPrecharge),
      .capDischarge(capDischarge), .irq(irq));

   analog_front_model #(.REF_LEVEL(REF_LEVEL)) front (.clk(clk),
      .analogSelect(analogSelect), .refRouteOn(refRouteOn),
      .sampleEnable(sampleEnable), .offset(offset), .convSample(convSample));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [15:0] lfsrNext(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [31:0] expVal(input int c, input logic isRef,
                                          input logic [9:0] off, input logic w10);
      logic [9:0] s;
      s = isRef ? (REF_LEVEL ^ off) : ({4'(c), 6'h2d} ^ off);
      return w10 ? {22'h0, s} : {24'h0, s[9:2]};
   endfunction

   // Sampled mid-cycle so register outputs have settled
   always @(negedge clk) begin
      if (sampleEnable === 1'b1) seRun++;
      else if (seRun != 0) begin
         seLen = seRun;
         seRun = 0;
         nConv++;
      end
      if (capPrecharge === 1'b1) pcCnt++;
      if (capDischarge === 1'b1) dcCnt++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         n_fail++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      d = regRdata;
   endtask

   task automatic waitConv(input int n);
      int target;
      target = nConv + n;
      for (int i = 0; i < 400 && nConv < target; i++) @(posedge clk);
      chk(32'(nConv >= target), 32'h1);
   endtask

   task automatic conv(input int c, input logic isRef, input logic w10, input logic aEn,
                       input logic aChg, input logic [1:0] trig, input logic mask);
      logic [31:0] d;
      int          idx;
      idx = isRef ? 0 : (c < 8 ? c : c - 8);
      lfsr = lfsrNext(lfsr);
      offset <= lfsr[9:0];
      wr(OFS_IRQ_MASK, {31'h0, mask});
      wr(OFS_INSEL, isRef ? 32'h0 : (c < 8 ? 32'(c) : 32'h10 | 32'(c - 8)));
      wr(OFS_CTRL_SECOND, {28'h0, aChg, aEn, w10, isRef});
      wr(OFS_REFCTRL, {31'h0, isRef});
      wr(OFS_MODE, {26'h0, trig, 2'h0, MODE_ONESHOT});
      pcCnt = 0;
      dcCnt = 0;
      wr(OFS_CTRL_FIRST, 32'h1);
      if (trig != TRIG_SOFT) begin
         repeat (20) @(posedge clk);
         chk({31'h0, sampleEnable}, 32'h0);
         if (trig == TRIG_TIMER) timerMatch <= 1'b1;
         else extTrigPin <= 1'b0;
         repeat (4) @(posedge clk);
         timerMatch <= 1'b0;
         extTrigPin <= 1'b1;
      end
      for (int i = 0; i < 50; i++) begin
         rd(OFS_IRQ_STATUS, d);
         if (d[0] === 1'b1) break;
      end
      chk(d, 32'h1);
      chk({31'h0, irq}, {31'h0, mask});
      chk({31'h0, refRouteOn}, {31'h0, isRef});
      rd(OFS_CTRL_FIRST, d);
      if (trig == TRIG_SOFT) chk(d, 32'h0);
      rd(OFS_RESULT0 + 8'(4 * idx), d);
      chk(d, expVal(c, isRef, offset, w10));
      // Sampling opens the cycle after the count loads, so that cycle is added
      chk(32'(seLen + 1 + pcCnt + dcCnt), aEn ? 32'd42 : 32'd40);
      chk(32'(pcCnt * 16 + dcCnt), aEn ? (aChg ? 32'h20 : 32'h2) : 32'h0);
      wr(OFS_IRQ_STATUS, 32'h1);
      if (trig != TRIG_SOFT) wr(OFS_CTRL_FIRST, 32'h0);
      rd(OFS_IRQ_STATUS, d);
      chk(d, 32'h0);
      chk({31'h0, irq}, 32'h0);
   endtask

   task automatic finish_test;
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      finish_test;
   end

   initial begin
      arst_n = 1'b0;
      regAddr = 8'h00;
      regWdata = 32'h0;
      regWr = 1'b0;
      regRd = 1'b0;
      timerMatch = 1'b0;
      extTrigPin = 1'b1;
      offset = 10'h000;
      lfsr = 16'h0014;
      n_fail = 0;
      checks_done = 0;
      seRun = 0;
      seLen = 0;
      nConv = 0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      wr(8'hfc, 32'hffff_ffff);
      for (int a = 0; a <= 8'h18; a += 4) begin
         rd(8'(a), rdv);
         chk(rdv, RST_ZERO);
      end
      rd(8'hfc, rdv);
      chk(rdv, 32'h0);
      for (int c = 0; c < 12; c++) begin
         conv(c, 1'b0, c[0], c == 4 || c == 5, c == 4,
              c == 6 ? TRIG_TIMER : (c == 7 ? TRIG_EXT : TRIG_SOFT), c != 7);
      end
      // Reference conversion with assist kept off
      conv(0, 1'b1, 1'b1, 1'b0, 1'b0, TRIG_SOFT, 1'b1);
      conv(0, 1'b1, 1'b0, 1'b0, 1'b0, TRIG_SOFT, 1'b1);
      wr(OFS_REFCTRL, 32'h0);
      wr(OFS_CTRL_SECOND, 32'h2);
      wr(OFS_INSEL, 32'h3);
      wr(OFS_CTRL_FIRST, 32'h1);
      repeat (10) @(posedge clk);
      wr(OFS_CTRL_FIRST, 32'h0);
      repeat (60) @(posedge clk);
      rd(OFS_IRQ_STATUS, rdv);
      chk(rdv, 32'h0);
      chk({30'h0, irq, sampleEnable}, 32'h0);
      offset <= 10'h011;
      wr(OFS_INSEL, 32'h11);
      wr(OFS_MODE, {30'h0, MODE_REPEAT0});
      wr(OFS_CTRL_FIRST, 32'h1);
      waitConv(2);
      rd(OFS_RESULT0 + 8'h04, rdv);
      chk(rdv, expVal(9, 1'b0, 10'h011, 1'b1));
      offset <= 10'h3c0;
      waitConv(2);
      rd(OFS_RESULT0 + 8'h04, rdv);
      chk(rdv, expVal(9, 1'b0, 10'h3c0, 1'b1));
      rd(OFS_CTRL_FIRST, rdv);
      chk(rdv, 32'h1);
      rd(OFS_IRQ_STATUS, rdv);
      chk(rdv, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_CTRL_FIRST, 32'h0);
      repeat (5) @(posedge clk);
      n0 = nConv;
      repeat (100) @(posedge clk);
      chk(32'(nConv - n0), 32'h0);
      chk({31'h0, sampleEnable}, 32'h0);
      finish_test;
   end
endmodule
`default_nettype wire

// ---- testbench/analog_front_model.sv ----
// Behavioural analog front end: channel pins and the on-chip reference level
`default_nettype none
module analog_front_model #(
   parameter logic [9:0] REF_LEVEL = 10'h2aa
) (
   // Clock
   input  wire logic       clk,
   // Selection from the sequencer
   input  wire logic [3:0] analogSelect,
   input  wire logic       refRouteOn,
   input  wire logic       sampleEnable,
   // Offset set by the bench
   input  wire logic [9:0] offset,
   // Level seen by the converter
   output logic      [9:0] convSample
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] level;
   assign level = refRouteOn ? (REF_LEVEL ^ offset) : ({analogSelect, 6'h2d} ^ offset);
   initial convSample = 10'h155;
   // Outside a conversion the line wanders, so a stale sample cannot pass
   always @(posedge clk) begin
      convSample <= sampleEnable ? level : ~convSample;
   end
endmodule
`default_nettype wire
